// file: rtl/nvpe_sequencer.v
/*
 * Flash program-once / erase / unsecure command sequencer.
 * Holds the indexed command parameter words, checks each launch and
 * walks check, work and verify steps against an array model port.
 * Assumes a single-cycle register master with reads answered one
 * cycle later, inputs synchronous to clk_i.
 */
// Chosen here: the plain strobed port and the placing of the registers.
// Functional notes
// - program-once checks erased, programs, verifies; complete stays low.
// - phrase index above 7 raises access error, command skipped.
// - program-once needs parameter index 101 at launch.
// - reprogramming a phrase is refused unless it was all ones.
// - flash reads return invalid data during program-once.
// - verify faults set verify error and uncorrectable flags.
// - erase-all is code 08, parameter index must be 000.
// - erase-all erases everything, verifies, unsecures only on success.
// - erase-all and unsecure refused with protection flag if protected; here only NVPE_CT_FLPROT or NVPE_CT_EEPROT refuse them, not NVPE_CT_SECPROT.
// - erase-block code 09, index 001, address bit 23 picks block.
// - bad address 22:16 is access error; protected block flagged.
// - erase-sector code 0a, index 001, sector holding the address.
// - sector address bits 1:0 nonzero is access error; protection flagged.
// - unsecure code 0b, index 000; failed verify keeps security.
// - clearing complete launches; complete sets only when fully done.
// - command not allowed in current mode raises access error.
`timescale 1ns/100ps
`include "nvpe_consts.vh"

module nvpe_sequencer #(
    parameter WORK_CYCLES = `NVPE_WORK_CYCLES,
    parameter BLOCK_HI_OK = 8'h00
) (
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    input  wire        verify_fail_i,
    input  wire        verify_uncorr_i,
    input  wire [15:0] flash_data_i,
    output reg  [15:0] flash_rdata_o,
    output wire        secured_o,
    output wire        busy_o
);

    localparam IDLE   = `NVPE_S_IDLE;
    localparam CHECK  = `NVPE_S_CHECK;
    localparam WORK   = `NVPE_S_WORK;
    localparam VERIFY = `NVPE_S_VERIFY;
    localparam DONE   = `NVPE_S_DONE;

    reg [15:0] command_param_word [0:5];
    reg [2:0]  param_index;
    reg        command_complete_flag;
    reg        access_error_flag;
    reg        protection_violation_flag;
    reg        verify_error_flag;
    reg        uncorrectable_verify_flag;
    reg [3:0]  ctrl;
    reg        secured;
    reg [2:0]  state;
    reg [15:0] cnt;
    reg [7:0]  once_done;
    reg [7:0]  once_ones;
    reg [7:0]  cur_cmd;

    wire [7:0]  cmd_code = command_param_word[`NVPE_SLOT_CMD][15:8];
    wire [7:0]  addr_hi  = command_param_word[`NVPE_SLOT_CMD][7:0];
    wire [15:0] addr_lo  = command_param_word[`NVPE_SLOT_ADDR];
    wire [2:0]  phrase   = addr_lo[2:0];
    wire        mode_ok  = ctrl[`NVPE_CT_MODEOK];
    wire        any_prot = ctrl[`NVPE_CT_FLPROT] | ctrl[`NVPE_CT_EEPROT];
    wire        launch   = wr_i && addr_i == `NVPE_OFS_STATUS &&
                           wdata_i[`NVPE_ST_CCF] && command_complete_flag;
    wire [15:0] status_word = {8'h00, command_complete_flag, 1'b0,
                               access_error_flag, protection_violation_flag,
                               2'b00, verify_error_flag,
                               uncorrectable_verify_flag};

    // Program data all ones, needed for the re-program exception
    function ones4;
        input [15:0] w0, w1, w2, w3;
        begin
            ones4 = (w0 & w1 & w2 & w3) == `NVPE_WORD_ONES;
        end
    endfunction

    // Launch-time access checks per command
    function acc_bad;
        input [7:0]  code;
        input [2:0]  ix;
        input [7:0]  ahi;
        input [15:0] alo;
        input        mok;
        input        prog_done;
        input        prog_ones;
        begin
            acc_bad = !mok;
            case (code)
                `NVPE_CMD_ONCE:
                    acc_bad = acc_bad || ix != `NVPE_IX_ONCE
                        || alo > `NVPE_PHRASE_MAX
                        || (prog_done && !prog_ones);
                `NVPE_CMD_ALL, `NVPE_CMD_UNSEC:
                    acc_bad = acc_bad || ix != `NVPE_IX_NONE;
                `NVPE_CMD_BLOCK:
                    acc_bad = acc_bad || ix != `NVPE_IX_ADDR
                        || ahi[6:0] != BLOCK_HI_OK[6:0];
                `NVPE_CMD_SECTOR:
                    acc_bad = acc_bad || ix != `NVPE_IX_ADDR
                        || ahi[6:0] != BLOCK_HI_OK[6:0]
                        || alo[1:0] != 2'b00;
                default:
                    acc_bad = 1'b1;
            endcase
        end
    endfunction

    // Protection check; block selector is address bit 23
    function prot_bad;
        input [7:0] code;
        input [7:0] ahi;
        input [3:0] c;
        begin
            case (code)
                `NVPE_CMD_ALL, `NVPE_CMD_UNSEC:
                    prot_bad = c[`NVPE_CT_FLPROT] |
                               c[`NVPE_CT_EEPROT];
                `NVPE_CMD_BLOCK:
                    prot_bad = ahi[7] ? c[`NVPE_CT_EEPROT]
                                      : c[`NVPE_CT_FLPROT];
                `NVPE_CMD_SECTOR:
                    prot_bad = c[`NVPE_CT_SECPROT];
                default:
                    prot_bad = 1'b0;
            endcase
        end
    endfunction

    assign secured_o = secured;
    assign busy_o    = !command_complete_flag;

    // Register writes into the parameter file; blocked while busy
    integer i;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < 6; i = i + 1)
                command_param_word[i] <= 16'h0000;
            param_index <= 3'h0;
            ctrl        <= 4'h0;
        end else if (wr_i && command_complete_flag) begin
            case (addr_i)
                `NVPE_OFS_INDEX:
                    param_index <= wdata_i[2:0];
                `NVPE_OFS_PARAM:
                    if (param_index <= `NVPE_IX_ONCE)
                        command_param_word[param_index] <= wdata_i;
                `NVPE_OFS_CTRL:
                    ctrl <= wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // Read port, data one cycle after the strobe
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                `NVPE_OFS_STATUS: rdata_o <= status_word;
                `NVPE_OFS_INDEX:  rdata_o <= {13'h0000, param_index};
                `NVPE_OFS_PARAM:  rdata_o <= (param_index <= `NVPE_IX_ONCE)
                                  ? command_param_word[param_index] : 16'h0000;
                `NVPE_OFS_CTRL:   rdata_o <= {12'h000, ctrl};
                `NVPE_OFS_SECURE: rdata_o <= {15'h0000, secured};
                default:          rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // Flash reads blanked while program-once is running
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            flash_rdata_o <= 16'h0000;
        else if (!command_complete_flag && cur_cmd == `NVPE_CMD_ONCE)
            flash_rdata_o <= `NVPE_WORD_ONES;
        else
            flash_rdata_o <= flash_data_i;
    end

    // Command state machine and status flags
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state                     <= IDLE;
            cnt                       <= 16'h0000;
            command_complete_flag     <= 1'b1;
            access_error_flag         <= 1'b0;
            protection_violation_flag <= 1'b0;
            verify_error_flag         <= 1'b0;
            uncorrectable_verify_flag <= 1'b0;
            secured                   <= 1'b1;
            once_done                 <= 8'h00;
            once_ones                 <= 8'h00;
            cur_cmd                   <= 8'h00;
        end else begin
            case (state)
                IDLE: begin
                    if (launch) begin
                        command_complete_flag     <= 1'b0;
                        access_error_flag         <= 1'b0;
                        protection_violation_flag <= 1'b0;
                        verify_error_flag         <= 1'b0;
                        uncorrectable_verify_flag <= 1'b0;
                        cur_cmd                   <= cmd_code;
                        state                     <= CHECK;
                    end
                end
                CHECK: begin
                    // Errors end the command without touching the array
                    if (acc_bad(cur_cmd, param_index, addr_hi, addr_lo,
                                mode_ok, once_done[phrase],
                                once_ones[phrase])) begin
                        access_error_flag <= 1'b1;
                        state             <= DONE;
                    end else if (prot_bad(cur_cmd, addr_hi, ctrl)) begin
                        protection_violation_flag <= 1'b1;
                        state                     <= DONE;
                    end else begin
                        cnt   <= WORK_CYCLES[15:0];
                        state <= WORK;
                    end
                end
                WORK: begin
                    // Erase or program step, fixed stand-in duration
                    if (cnt == `NVPE_CNT_ONE)
                        state <= VERIFY;
                    cnt <= cnt - `NVPE_CNT_ONE;
                end
                VERIFY: begin
                    verify_error_flag         <= verify_fail_i;
                    uncorrectable_verify_flag <= verify_uncorr_i;
                    if (!verify_fail_i) begin
                        if (cur_cmd == `NVPE_CMD_ALL ||
                            cur_cmd == `NVPE_CMD_UNSEC)
                            secured <= 1'b0;
                        if (cur_cmd == `NVPE_CMD_ONCE) begin
                            once_done[phrase] <= 1'b1;
                            once_ones[phrase] <= ones4(
                                command_param_word[2], command_param_word[3],
                                command_param_word[4], command_param_word[5]);
                        end
                    end
                    state <= DONE;
                end
                DONE: begin
                    command_complete_flag <= 1'b1;
                    state                 <= IDLE;
                end
                default: state <= IDLE;
            endcase
        end
    end

endmodule

// file: pkg/nvpe_consts.vh
/*
 * Constants of the flash program/erase command sequencer: register
 * offsets, field positions, command codes and state codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef NVPE_CONSTS_VH
`define NVPE_CONSTS_VH

// Register offsets (word address on the plain register port)
`define NVPE_OFS_STATUS   4'h0
`define NVPE_OFS_INDEX    4'h1
`define NVPE_OFS_PARAM    4'h2
`define NVPE_OFS_CTRL     4'h3
`define NVPE_OFS_SECURE   4'h4

// Status bits
`define NVPE_ST_CCF       7
`define NVPE_ST_ACC       5
`define NVPE_ST_PROT      4
`define NVPE_ST_VERR      1
`define NVPE_ST_UNC       0

// Control bits
`define NVPE_CT_MODEOK    0
`define NVPE_CT_FLPROT    1
`define NVPE_CT_EEPROT    2
`define NVPE_CT_SECPROT   3

// Command codes
`define NVPE_CMD_ONCE     8'h07
`define NVPE_CMD_ALL      8'h08
`define NVPE_CMD_BLOCK    8'h09
`define NVPE_CMD_SECTOR   8'h0a
`define NVPE_CMD_UNSEC    8'h0b

// Required parameter index at launch
`define NVPE_IX_ONCE      3'h5
`define NVPE_IX_NONE      3'h0
`define NVPE_IX_ADDR      3'h1

// Parameter slots
`define NVPE_SLOT_CMD     3'h0
`define NVPE_SLOT_ADDR    3'h1
`define NVPE_SLOT_DATA    3'h2

// Phrase index range, all-ones phrase and erased word
`define NVPE_PHRASE_MAX   16'h0007
`define NVPE_WORD_ONES    16'hffff

// Sequencer states
`define NVPE_S_IDLE       3'h0
`define NVPE_S_CHECK      3'h1
`define NVPE_S_WORK       3'h2
`define NVPE_S_VERIFY     3'h3
`define NVPE_S_DONE       3'h4

// Default work time in clock cycles
`define NVPE_WORK_CYCLES  8
`define NVPE_CNT_ONE      16'h0001

`endif

// file: sim/nvpe_sequencer_asserts.sv
/* Port checker for the flash command sequencer.
 * Bound to every sequencer instance; it sees that module's ports only. */
`timescale 1ns/100ps
module nvpe_sequencer_asserts #(
    parameter WORK_CYCLES = 8
) (
    input wire        clk_i,
    input wire        rstn_i,
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [15:0] rdata_o,
    input wire        verify_fail_i,
    input wire        verify_uncorr_i,
    input wire [15:0] flash_data_i,
    input wire [15:0] flash_rdata_o,
    input wire        secured_o,
    input wire        busy_o
);
    // Generous bound, well above the longest work count in use
    localparam int BUSY_MAX = 60;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Launch write while idle, then the busy span it opens
    sequence s_launch;
        wr_i && addr_i == 4'h0 && wdata_i[7] && !busy_o;
    endsequence
    sequence s_run;
        busy_o [*2];
    endsequence
    launch_busy_a: assert property (s_launch |=> s_run)
        else $error("launch did not hold busy");
    busy_bound_a: assert property ($rose(busy_o) |-> ##[1:BUSY_MAX] !busy_o)
        else $error("command never completed");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(wr_i)
        && $past(addr_i) == 4'h0 && $past(wdata_i[7]))
        else $error("busy rose without a launch");
    status_low_a: assert property (rd_i && addr_i == 4'h0 && busy_o
        |=> !rdata_o[7]) else $error("complete read high while busy");
    status_high_a: assert property (rd_i && addr_i == 4'h0 && !busy_o
        |=> rdata_o[7]) else $error("complete read low while idle");
    read_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside its cycle");
    // Reset clears the flash output, so the cycle after release is skipped
    flash_pass_a: assert property (!busy_o && !$past(busy_o) && $past(rstn_i)
        |-> flash_rdata_o == $past(flash_data_i))
        else $error("idle flash read not passed through");
    secure_rise_a: assert property (!$rose(secured_o))
        else $error("security raised outside reset");
    secure_end_a: assert property ($fell(secured_o) |-> $past(busy_o))
        else $error("security released outside a command");
endmodule

bind nvpe_sequencer nvpe_sequencer_asserts #(.WORK_CYCLES(WORK_CYCLES)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .verify_fail_i(verify_fail_i), .verify_uncorr_i(verify_uncorr_i),
    .flash_data_i(flash_data_i), .flash_rdata_o(flash_rdata_o),
    .secured_o(secured_o), .busy_o(busy_o));

// file: sim/nvpe_sequencer_tb.sv
/* Self-checking bench for the flash command sequencer.
 * Assumes the constants header on the include path. */
`timescale 1ns/100ps
`include "nvpe_consts.vh"
module nvpe_sequencer_tb;
    reg         clk_i = 1'b0;
    reg         rstn_i = 1'b0;
    reg  [3:0]  addr_i = 4'h0;
    reg  [15:0] wdata_i = 16'h0000;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    reg         verify_fail_i = 1'b0;
    reg         verify_uncorr_i = 1'b0;
    reg  [15:0] flash_data_i = 16'h1234;
    wire [15:0] rdata_o;
    wire [15:0] flash_rdata_o;
    wire        secured_o;
    wire        busy_o;
    integer     n_errors = 0;
    integer     n_compared = 0;
    integer     i;
    localparam [15:0] OK = 16'h0080, ACC = 16'h00a0, PROT = 16'h0090;

    always #2.5 clk_i = ~clk_i;

    // Short work count keeps each command a handful of cycles
    nvpe_sequencer #(.WORK_CYCLES(2)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .verify_fail_i(verify_fail_i), .verify_uncorr_i(verify_uncorr_i),
        .flash_data_i(flash_data_i), .flash_rdata_o(flash_rdata_o),
        .secured_o(secured_o), .busy_o(busy_o));

    task summarize;
        begin
            $display("errors=%0d compared=%0d", n_errors, n_compared);
            if (n_errors == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task cmp(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Bus cycles; a free edge follows each so strobes never re-raise at once
    task wr(input [3:0] a, input [15:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask

    task rd(input [3:0] a, output [15:0] v);
        begin
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1 v = rdata_o;
            @(posedge clk_i);
        end
    endtask

    task put(input [2:0] s, input [15:0] v);
        begin
            wr(`NVPE_OFS_INDEX, {13'h0000, s});
            wr(`NVPE_OFS_PARAM, v);
        end
    endtask

    // Load, launch, wait for completion, judge the status flags
    task run(input [7:0] c, input [7:0] h, input [15:0] lo, input [2:0] ix,
             input [3:0] ct, input [15:0] e, input fl);
        reg [15:0] v;
        begin
            wr(`NVPE_OFS_CTRL, {12'h000, ct});
            put(`NVPE_SLOT_CMD, {c, h});
            put(`NVPE_SLOT_ADDR, lo);
            wr(`NVPE_OFS_INDEX, {13'h0000, ix});
            wr(`NVPE_OFS_STATUS, 16'h0080);
            if (fl) begin
                @(posedge clk_i);
                #1 cmp(flash_rdata_o, 16'hffff);
            end
            // No register write until complete returns
            repeat (4) if (busy_o !== 1'b1) @(posedge clk_i);
            repeat (40) if (busy_o !== 1'b0) @(posedge clk_i);
            rd(`NVPE_OFS_STATUS, v);
            cmp(v & 16'h00b3, e);
        end
    endtask

    task t_reset;
        reg [15:0] v;
        begin
            rd(`NVPE_OFS_STATUS, v);
            cmp(v & 16'h00b3, OK);
            cmp({15'h0000, secured_o}, 16'h0001);
            cmp(flash_rdata_o, 16'h1234);
        end
    endtask

    // Each code 07 to 0b launched with mode not allowed must give access error
    task t_mode;
        begin
            for (i = 7; i < 12; i = i + 1)
                run(i[7:0], 8'h00, 16'h0000, 3'h0, 4'h0, ACC, 1'b0);
        end
    endtask

    task t_index;
        begin
            run(`NVPE_CMD_ALL, 8'h00, 16'h0000, 3'h1, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_UNSEC, 8'h00, 16'h0000, 3'h1, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_BLOCK, 8'h00, 16'h0000, 3'h0, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_SECTOR, 8'h00, 16'h0000, 3'h0, 4'h1, ACC, 1'b0);
        end
    endtask

    task t_prot;
        begin
            run(`NVPE_CMD_ALL, 8'h00, 16'h0000, 3'h0, 4'h3, PROT, 1'b0);
            run(`NVPE_CMD_UNSEC, 8'h00, 16'h0000, 3'h0, 4'h5, PROT, 1'b0);
            run(`NVPE_CMD_BLOCK, 8'h80, 16'h0000, 3'h1, 4'h5, PROT, 1'b0);
            run(`NVPE_CMD_BLOCK, 8'h00, 16'h0000, 3'h1, 4'h5, OK, 1'b0);
            run(`NVPE_CMD_SECTOR, 8'h00, 16'h0104, 3'h1, 4'h9, PROT, 1'b0);
        end
    endtask

    task t_addr;
        begin
            run(`NVPE_CMD_BLOCK, 8'h01, 16'h0000, 3'h1, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_SECTOR, 8'h00, 16'h0102, 3'h1, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_SECTOR, 8'h00, 16'h01fc, 3'h1, 4'h1, OK, 1'b0);
        end
    endtask

    task t_once;
        begin
            for (i = 2; i < 6; i = i + 1)
                put(i[2:0], 16'ha5a5);
            run(`NVPE_CMD_ONCE, 8'h00, 16'h0008, 3'h5, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_ONCE, 8'h00, 16'h0007, 3'h4, 4'h1, ACC, 1'b0);
            run(`NVPE_CMD_ONCE, 8'h00, 16'h0007, 3'h5, 4'h1, OK, 1'b1);
            run(`NVPE_CMD_ONCE, 8'h00, 16'h0007, 3'h5, 4'h1, ACC, 1'b0);
            for (i = 2; i < 6; i = i + 1)
                put(i[2:0], 16'hffff);
            run(`NVPE_CMD_ONCE, 8'h00, 16'h0000, 3'h5, 4'h1, OK, 1'b0);
            run(`NVPE_CMD_ONCE, 8'h00, 16'h0000, 3'h5, 4'h1, OK, 1'b0);
        end
    endtask

    task t_secure;
        begin
            verify_fail_i <= 1'b1;
            run(`NVPE_CMD_UNSEC, 8'h00, 16'h0000, 3'h0, 4'h1, 16'h0082, 1'b0);
            cmp({15'h0000, secured_o}, 16'h0001);
            verify_uncorr_i <= 1'b1;
            run(`NVPE_CMD_SECTOR, 8'h00, 16'h0000, 3'h1, 4'h1, 16'h0083, 1'b0);
            verify_fail_i <= 1'b0;
            verify_uncorr_i <= 1'b0;
            run(`NVPE_CMD_ALL, 8'h00, 16'h0000, 3'h0, 4'h1, OK, 1'b0);
            cmp({15'h0000, secured_o}, 16'h0000);
        end
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        #50000;
        n_errors = n_errors + 1;
        summarize;
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_mode;
        t_index;
        t_prot;
        t_addr;
        t_once;
        t_secure;
        summarize;
    end
endmodule
